// ### rtl/gpb_host_port.sv
// host parallel bus port: lane routing, fifo packing, dma, cycle stretch
`timescale 1ns/1ns
module gpb_host_port #(
  parameter int LIMIT_W = 16
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  // host pins
  input wire logic i_lane_a_select_n,
  input wire logic i_lane_b_select_n,
  input wire logic i_chip_sel_n,
  input wire logic i_read_strobe_n,
  input wire logic i_write_strobe_n,
  input wire logic i_dma_ack_n,
  input wire logic i_prefetch_read_n,
  input wire logic [4:0] i_addr,
  input wire logic [7:0] i_lane_a_data,
  input wire logic [7:0] i_lane_b_data,
  output logic [7:0] o_lane_a_data,
  output logic [7:0] o_lane_b_data,
  output logic o_lane_a_oe_n,
  output logic o_lane_b_oe_n,
  output logic o_lane_a_drive_en_n,
  output logic o_lane_b_drive_en_n,
  output logic o_cycle_stretch_flag,
  output logic o_cycle_ready,
  output logic o_dma_request,
  output logic o_host_interrupt,
  output logic o_fifo_ready,
  input wire logic i_page_in_select,
  input wire logic i_mode_strap,
  input wire logic i_swap_strap_n,
  // state toward the core
  output logic o_page_in,
  output logic o_swap_flag,
  output gpb_pkg::gpb_mode_t o_mode,
  output logic o_fifo_ready_status_bit,
  // configuration and status from the core
  input wire logic i_one_chip_mode,
  input wire logic i_lane_a_first,
  input wire logic i_word_width_select,
  input wire logic i_dir_in,
  input wire logic i_dma_limit_enable,
  input wire logic i_limit_by_time_or_count,
  input wire logic [LIMIT_W-1:0] i_limit_value,
  input wire logic [7:0] i_interrupt_status_three,
  input wire logic [7:0] i_interrupt_enable_three,
  input wire logic i_internal_busy,
  input wire logic [7:0] i_rx_bytes,
  input wire logic [7:0] i_tx_room,
  // receive fifo head
  input wire gpb_pkg::gpb_word_t i_rx_word,
  output logic o_rx_pop,
  // transmit words
  output gpb_pkg::gpb_word_t o_tx_word,
  output logic o_tx_valid,
  input wire logic i_tx_ready,
  // register access toward the core
  output logic [4:0] o_reg_addr,
  output logic [7:0] o_reg_wdata,
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic o_reg_legacy,
  input wire logic [7:0] i_reg_rdata
);

  if (LIMIT_W < 1 || LIMIT_W > 32)
  begin : g_bad_limit
    $error("gpb_host_port limit width must be 1 to 32");
  end

  gpb_pkg::gpb_pins_t pin_meta;
  gpb_pkg::gpb_pins_t p;
  logic [1:0] strap_meta;
  logic [1:0] strap_sync;
  logic in_reset;
  gpb_pkg::gpb_mode_t strap_mode;
  gpb_pkg::gpb_state_t state;
  logic acc_dma;
  logic acc_io;
  logic sel_a;
  logic sel_b;
  logic dec_two;
  logic dec_fifo;
  logic dec_ok;
  logic dec_legacy;
  logic start;
  logic a_dma;
  logic a_two;
  logic a_on_a;
  logic a_fifo;
  logic a_read;
  logic a_legacy;
  logic [4:0] a_addr;
  logic [1:0] rd_wait;
  gpb_pkg::gpb_lanes_t wr_hold;
  gpb_pkg::gpb_lanes_t rx_lanes;
  logic can_go;
  logic buf_in_valid;
  logic buf_in_ready;
  gpb_pkg::gpb_word_t buf_in_word;
  logic dma_xfer;
  logic [LIMIT_W-1:0] lim_cnt;
  logic dma_cond;
  logic [7:0] dma_need;
  logic drive_a_n;
  logic drive_b_n;

  // two-stage synchroniser for all host pins
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      pin_meta <= gpb_pkg::PINS_IDLE;
      p <= gpb_pkg::PINS_IDLE;
    end
    else
    begin
      pin_meta <= {i_lane_a_select_n, i_lane_b_select_n, i_chip_sel_n, i_read_strobe_n, i_write_strobe_n,
        i_dma_ack_n, i_prefetch_read_n, i_page_in_select, i_addr, i_lane_a_data, i_lane_b_data};
      p <= pin_meta;
    end
  end

  // strap synchroniser runs through reset so the straps are seen while it is held
  always_ff @(posedge i_clk)
  begin
    strap_meta <= {i_mode_strap, i_swap_strap_n};
    strap_sync <= strap_meta;
  end

  // marks the reset period; clears on the first edge after release
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      in_reset <= 1'b1;
    end
    else
    begin
      in_reset <= 1'b0;
    end
  end

  // strap capture while reset is held
  always_ff @(posedge i_clk)
  begin
    if (in_reset)
    begin
      strap_mode <= strap_sync[1] ? gpb_pkg::MODE_COMPAT_A : gpb_pkg::MODE_COMPAT_B;
      o_swap_flag <= !strap_sync[0];
    end
  end

  // mode and page-in state seen by the core
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_mode <= gpb_pkg::MODE_COMPAT_A;
      o_page_in <= 1'b0;
    end
    else
    begin
      o_mode <= (i_one_chip_mode && !in_reset) ? gpb_pkg::MODE_ONE_CHIP : strap_mode;
      o_page_in <= p.page && (o_mode != gpb_pkg::MODE_COMPAT_B);
    end
  end

  // access decode from the synchronised pins
  assign acc_dma = !p.dack_n;
  assign acc_io = p.dack_n && !p.cs_n;
  assign sel_a = !p.a_sel_n;
  assign sel_b = !p.b_sel_n;
  assign dec_two = sel_a && sel_b;
  assign dec_fifo = acc_dma || (p.addr == gpb_pkg::FIFO_OFFSET);
  assign dec_ok = acc_dma ? sel_b : (acc_io && (sel_a || sel_b) && (!dec_two || dec_fifo));
  assign dec_legacy = acc_io && (o_mode != gpb_pkg::MODE_ONE_CHIP) && gpb_pkg::LEGACY_MAP[p.addr];
  assign start = p.rd_n ^ p.wr_n;
  assign rx_lanes = gpb_pkg::lane_order(i_rx_word.first, i_rx_word.second, i_lane_a_first);
  assign can_go = !(a_legacy && i_internal_busy) && !(a_fifo && !a_read && !buf_in_ready);

  // access sequencer
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state <= gpb_pkg::ST_IDLE;
      a_dma <= 1'b0;
      a_two <= 1'b0;
      a_on_a <= 1'b0;
      a_fifo <= 1'b0;
      a_read <= 1'b0;
      a_legacy <= 1'b0;
      a_addr <= 5'h00;
    end
    else
    begin
      unique case (state)
        gpb_pkg::ST_IDLE:
        begin
          if (start && dec_ok)
          begin
            state <= gpb_pkg::ST_WAIT;
            a_dma <= acc_dma;
            a_two <= dec_two;
            a_on_a <= sel_a && !sel_b;
            a_fifo <= dec_fifo;
            a_read <= !p.rd_n;
            a_legacy <= dec_legacy;
            a_addr <= p.addr;
          end
        end
        gpb_pkg::ST_WAIT:
        begin
          if (p.rd_n && p.wr_n)
          begin
            state <= gpb_pkg::ST_IDLE;
          end
          else if (can_go)
          begin
            state <= a_read ? gpb_pkg::ST_READ : gpb_pkg::ST_WRITE;
          end
        end
        gpb_pkg::ST_READ:
        begin
          if (p.rd_n)
          begin
            state <= gpb_pkg::ST_IDLE;
          end
        end
        gpb_pkg::ST_WRITE:
        begin
          if (p.wr_n)
          begin
            state <= gpb_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // stretch flag and ready toward the host
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_cycle_stretch_flag <= 1'b0;
      o_cycle_ready <= 1'b0;
    end
    else
    begin
      if (state == gpb_pkg::ST_IDLE)
      begin
        o_cycle_stretch_flag <= start && dec_ok && dec_legacy && !acc_dma;
      end
      else if ((state == gpb_pkg::ST_READ && p.rd_n) || (state == gpb_pkg::ST_WRITE && p.wr_n))
      begin
        o_cycle_stretch_flag <= 1'b0;
      end
      // ready on every access once written data can be taken or read data is driven
      o_cycle_ready <= ((state == gpb_pkg::ST_WRITE) && !p.wr_n)
        || ((state == gpb_pkg::ST_READ) && !p.rd_n && (rd_wait == 2'h0));
    end
  end

  // register strobes and read-data wait toward the core
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_reg_rd <= 1'b0;
      o_reg_wr <= 1'b0;
      o_reg_addr <= 5'h00;
      o_reg_wdata <= 8'h00;
      o_reg_legacy <= 1'b0;
      rd_wait <= 2'h0;
    end
    else
    begin
      o_reg_rd <= (state == gpb_pkg::ST_WAIT) && can_go && a_read && !a_fifo && !p.rd_n;
      o_reg_wr <= (state == gpb_pkg::ST_WRITE) && p.wr_n && !a_fifo;
      if (state == gpb_pkg::ST_WAIT)
      begin
        o_reg_addr <= a_addr;
        o_reg_legacy <= a_legacy;
      end
      if ((state == gpb_pkg::ST_WRITE) && p.wr_n)
      begin
        o_reg_wdata <= a_on_a ? wr_hold.a : wr_hold.b;
      end
      if ((state == gpb_pkg::ST_WAIT) && can_go && a_read)
      begin
        rd_wait <= a_fifo ? 2'h0 : gpb_pkg::RD_WAIT_LOAD;
      end
      else
      begin
        rd_wait <= rd_wait >> 1;
      end
    end
  end

  // write data held while the strobe is low, so the value before its rise is used
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      wr_hold <= '0;
    end
    else if ((state == gpb_pkg::ST_WRITE) && !p.wr_n)
    begin
      wr_hold <= p.data;
    end
  end

  // fifo write words into the buffer at the write strobe rise
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      buf_in_valid <= 1'b0;
      buf_in_word <= '0;
    end
    else
    begin
      buf_in_valid <= (state == gpb_pkg::ST_WRITE) && p.wr_n && a_fifo;
      if ((state == gpb_pkg::ST_WRITE) && p.wr_n)
      begin
        if (a_two)
        begin
          buf_in_word <= {1'b1, gpb_pkg::lane_order(wr_hold.a, wr_hold.b, i_lane_a_first)};
        end
        else
        begin
          buf_in_word <= {1'b0, (a_on_a ? wr_hold.a : wr_hold.b), 8'h00};
        end
      end
    end
  end

  // write-word buffer; when full the next fifo write waits with ready low
  gpb_pair_buf #(
    .WIDTH($bits(gpb_pkg::gpb_word_t)),
    .DEPTH(gpb_pkg::BUF_DEPTH)
  ) u_tx_buf (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_valid(buf_in_valid),
    .o_ready(buf_in_ready),
    .i_data(buf_in_word),
    .o_valid(o_tx_valid),
    .i_ready(i_tx_ready),
    .o_data(o_tx_word)
  );

  // lane drivers for reads and prefetch
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      drive_a_n <= 1'b1;
      drive_b_n <= 1'b1;
      o_lane_a_data <= 8'h00;
      o_lane_b_data <= 8'h00;
    end
    else if ((state == gpb_pkg::ST_READ) && !p.rd_n)
    begin
      if (a_fifo && a_two)
      begin
        o_lane_a_data <= rx_lanes.a;
        o_lane_b_data <= rx_lanes.b;
        drive_a_n <= 1'b0;
        drive_b_n <= 1'b0;
      end
      else if (a_fifo)
      begin
        o_lane_a_data <= i_rx_word.first;
        o_lane_b_data <= i_rx_word.first;
        drive_a_n <= !a_on_a;
        drive_b_n <= a_on_a;
      end
      else if (rd_wait == gpb_pkg::RD_WAIT_TAKE)
      begin
        o_lane_a_data <= i_reg_rdata;
        o_lane_b_data <= i_reg_rdata;
        drive_a_n <= !a_on_a;
        drive_b_n <= a_on_a;
      end
    end
    else if ((state == gpb_pkg::ST_IDLE) && !p.pref_n && p.rd_n && p.wr_n)
    begin
      o_lane_a_data <= rx_lanes.a;
      o_lane_b_data <= rx_lanes.b;
      drive_a_n <= 1'b0;
      drive_b_n <= 1'b0;
    end
    else
    begin
      drive_a_n <= 1'b1;
      drive_b_n <= 1'b1;
    end
  end

  assign o_lane_a_oe_n = drive_a_n;
  assign o_lane_b_oe_n = drive_b_n;
  assign o_lane_a_drive_en_n = drive_a_n;
  assign o_lane_b_drive_en_n = drive_b_n;

  // fifo pop at the end of a read, dma transfer count at the end of a read or write; prefetch never pops
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_rx_pop <= 1'b0;
      dma_xfer <= 1'b0;
    end
    else
    begin
      o_rx_pop <= (state == gpb_pkg::ST_READ) && p.rd_n && a_fifo;
      dma_xfer <= a_dma && (((state == gpb_pkg::ST_READ) && p.rd_n) || ((state == gpb_pkg::ST_WRITE) && p.wr_n));
    end
  end

  // dma request condition from fill or room
  assign dma_need = i_word_width_select ? gpb_pkg::DMA_WORD_BYTES : gpb_pkg::DMA_BYTE_BYTES;
  assign dma_cond = i_dir_in ? (i_rx_bytes >= dma_need) : (i_tx_room >= dma_need);

  // limit counter: cycles of request or transfers made
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      lim_cnt <= LIMIT_W'(gpb_pkg::LIMIT_RESET);
    end
    else if (!dma_cond || !i_dma_limit_enable)
    begin
      lim_cnt <= LIMIT_W'(gpb_pkg::LIMIT_RESET);
    end
    else if (lim_cnt != i_limit_value)
    begin
      if (i_limit_by_time_or_count ? o_dma_request : dma_xfer)
      begin
        lim_cnt <= lim_cnt + 1'b1;
      end
    end
  end

  // dma request, fifo-ready and interrupt outputs
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_dma_request <= 1'b0;
      o_fifo_ready <= 1'b0;
      o_fifo_ready_status_bit <= 1'b0;
      o_host_interrupt <= 1'b0;
    end
    else
    begin
      o_dma_request <= dma_cond && !(i_dma_limit_enable && (lim_cnt == i_limit_value));
      o_fifo_ready <= i_dir_in ? (i_rx_bytes >= gpb_pkg::FIFO_READY_LEVEL)
        : (i_tx_room >= gpb_pkg::FIFO_READY_LEVEL);
      o_fifo_ready_status_bit <= (o_mode == gpb_pkg::MODE_ONE_CHIP) && (i_dir_in
        ? (i_rx_bytes >= gpb_pkg::FIFO_READY_LEVEL) : (i_tx_room >= gpb_pkg::FIFO_READY_LEVEL));
      o_host_interrupt <= |(i_interrupt_status_three & i_interrupt_enable_three);
    end
  end

endmodule

// ### rtl/gpb_pair_buf.sv
// small valid/ready buffer for host write words
`timescale 1ns/1ns
module gpb_pair_buf #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 2
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // pointers wrap by power of two only
  if ((DEPTH < 2) || ((DEPTH & (DEPTH - 1)) != 0))
  begin : g_bad_depth
    $error("gpb_pair_buf depth must be a power of two of at least two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic push;
  logic pop;

  // handshakes on both sides
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;
  assign o_ready = (count != (PW+1)'(DEPTH));
  assign o_valid = (count != '0);
  assign o_data = mem[rd_ptr];

  // storage
  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= i_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop)
      begin
        count <= count + 1'b1;
      end
      else if (pop && !push)
      begin
        count <= count - 1'b1;
      end
    end
  end

endmodule

// ### rtl/gpb_pkg.sv
// shared constants, carriers and helpers for the gpib host bus port
package gpb_pkg;

  // register offset that reaches the data fifos
  localparam logic [4:0] FIFO_OFFSET = 5'h18;
  // one bit per offset: set where the offset lies in the legacy register space
  localparam logic [31:0] LEGACY_MAP = 32'hA8AA5555;
  // fifo-ready threshold in bytes of fill or room
  localparam logic [7:0] FIFO_READY_LEVEL = 8'h08;
  // fill or room needed for a dma request in word and in byte width
  localparam logic [7:0] DMA_WORD_BYTES = 8'h02;
  localparam logic [7:0] DMA_BYTE_BYTES = 8'h01;
  // entries of the write-data buffer
  localparam int BUF_DEPTH = 2;
  // reset value of the dma limit counter
  localparam logic [15:0] LIMIT_RESET = 16'h0000;
  // read-wait shift pattern: register data returns the cycle after the read pulse
  localparam logic [1:0] RD_WAIT_LOAD = 2'h2;
  localparam logic [1:0] RD_WAIT_TAKE = 2'h1;

  // one fifo word as seen from the gpib side, first byte leaves first
  typedef struct packed {
    logic two;
    logic [7:0] first;
    logic [7:0] second;
  } gpb_word_t;

  // the two host byte lanes
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
  } gpb_lanes_t;

  // every host pin that is sampled through the synchroniser
  typedef struct packed {
    logic a_sel_n;
    logic b_sel_n;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic dack_n;
    logic pref_n;
    logic page;
    logic [4:0] addr;
    gpb_lanes_t data;
  } gpb_pins_t;

  // idle level of the pins: all strobes and selects released
  localparam gpb_pins_t PINS_IDLE = gpb_pins_t'({8'hFE, 5'h00, 16'h0000});

  typedef enum logic [2:0] {
    MODE_COMPAT_A = 3'b001,
    MODE_COMPAT_B = 3'b010,
    MODE_ONE_CHIP = 3'b100
  } gpb_mode_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WAIT = 4'b0010,
    ST_READ = 4'b0100,
    ST_WRITE = 4'b1000
  } gpb_state_t;

  // places two bytes on the lanes, x on lane a when a_first is set
  function automatic gpb_lanes_t lane_order(input logic [7:0] x, input logic [7:0] y, input logic a_first);
    gpb_lanes_t r;
    r = a_first ? {x, y} : {y, x};
    return r;
  endfunction

endpackage

// ### verif/gpb_host_model.sv
// host side bus model driving the port's pins
`timescale 1ns/1ns
module gpb_host_model (
  input wire logic i_clk,
  input wire logic i_ready,
  input wire logic [7:0] i_a,
  input wire logic [7:0] i_b,
  output gpb_pkg::gpb_pins_t o_pins
);
  initial o_pins = gpb_pkg::PINS_IDLE;
  // one access: request held until ready is seen or the bound runs out
  task automatic access(input logic dma, input logic rd, input logic [1:0] ln, input logic [4:0] adr,
    input logic [15:0] wd, output logic [15:0] rdat, output logic ok);
    int n;
    gpb_pkg::gpb_pins_t p;
    p = gpb_pkg::PINS_IDLE;
    p.a_sel_n = ln[1];
    p.b_sel_n = ln[0];
    p.cs_n = dma;
    p.dack_n = !dma;
    p.addr = adr;
    p.rd_n = !rd;
    p.wr_n = rd;
    p.data = rd ? ~o_pins.data : wd; // lanes not held last value when host does not drive
    ok = 1'h0;
    @(posedge i_clk);
    o_pins <= p;
    for (n = 0; n < 60 && ok !== 1'h1; n++)
    begin
      @(posedge i_clk);
      ok = i_ready;
    end
    rdat = {i_a, i_b};
    o_pins <= {gpb_pkg::PINS_IDLE[28:16], ~p.data};
    repeat (6) @(posedge i_clk);
  endtask
  // prefetch and page-in levels
  task automatic set_lvl(input logic pref_n, input logic page);
    @(posedge i_clk);
    o_pins.pref_n <= pref_n;
    o_pins.page <= page;
  endtask
endmodule

// ### verif/gpb_port_monitor.sv
// checker for the host bus port, attached to the port by bind
`timescale 1ns/1ns
module gpb_port_monitor (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_read_strobe_n,
  input wire logic i_write_strobe_n,
  input wire logic i_prefetch_read_n,
  input wire logic i_dma_ack_n,
  input wire logic i_chip_sel_n,
  input wire logic i_one_chip_mode,
  input wire logic i_dir_in,
  input wire logic [7:0] i_rx_bytes,
  input wire logic [7:0] i_tx_room,
  input wire logic [7:0] i_interrupt_status_three,
  input wire logic [7:0] i_interrupt_enable_three,
  input wire logic o_lane_a_oe_n,
  input wire logic o_lane_b_oe_n,
  input wire logic o_lane_a_drive_en_n,
  input wire logic o_cycle_stretch_flag,
  input wire logic o_host_interrupt,
  input wire logic o_fifo_ready,
  input wire logic o_fifo_ready_status_bit,
  input wire logic o_page_in,
  input wire gpb_pkg::gpb_mode_t o_mode,
  input wire logic o_rx_pop,
  input wire logic o_reg_wr
);
  // one clock domain: shared clock and reset
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  property p_drive_ind;
    !o_lane_a_drive_en_n |-> !$past(i_read_strobe_n, 3) || !$past(i_prefetch_read_n, 3);
  endproperty
  a_drive_ind: assert property (p_drive_ind) else $error("lane a driven outside a read");
  property p_no_drive;
    (i_read_strobe_n && i_prefetch_read_n) [*6] |-> o_lane_a_oe_n && o_lane_b_oe_n;
  endproperty
  a_no_drive: assert property (p_no_drive) else $error("lane driven without read");
  property p_wr_rise;
    o_reg_wr |-> $past(i_write_strobe_n, 3);
  endproperty
  a_wr_rise: assert property (p_wr_rise) else $error("write taken before strobe rise");
  property p_one_chip;
    i_one_chip_mode && $past(i_one_chip_mode, 4) |-> !o_cycle_stretch_flag;
  endproperty
  a_one_chip: assert property (p_one_chip) else $error("stretch raised in one-chip mode");
  property p_dma_stretch;
    (!i_dma_ack_n) [*4] |-> !o_cycle_stretch_flag;
  endproperty
  a_dma_stretch: assert property (p_dma_stretch) else $error("stretch raised during dma");
  property p_int;
    $past(i_resetn) |-> o_host_interrupt == |$past(i_interrupt_status_three & i_interrupt_enable_three);
  endproperty
  a_int: assert property (p_int) else $error("interrupt output wrong");
  property p_fifo_rdy;
    $past(i_resetn) |-> o_fifo_ready == $past(i_dir_in ? i_rx_bytes >= 8'h08 : i_tx_room >= 8'h08);
  endproperty
  a_fifo_rdy: assert property (p_fifo_rdy) else $error("fifo ready wrong");
  property p_rdy_bit;
    $past(i_resetn) |-> o_fifo_ready_status_bit == (o_fifo_ready && $past(i_one_chip_mode, 2));
  endproperty
  a_rdy_bit: assert property (p_rdy_bit) else $error("fifo ready status bit wrong");
  property p_page;
    o_page_in |-> o_mode != gpb_pkg::MODE_COMPAT_B;
  endproperty
  a_page: assert property (p_page) else $error("page-in in second compatibility mode");
  property p_no_pop;
    (i_dma_ack_n && i_chip_sel_n) [*6] |-> !o_rx_pop;
  endproperty
  a_no_pop: assert property (p_no_pop) else $error("fifo word removed without read");
endmodule
bind gpb_host_port gpb_port_monitor gpb_port_monitor_inst (.i_clk, .i_resetn, .i_read_strobe_n,
  .i_write_strobe_n, .i_prefetch_read_n, .i_dma_ack_n, .i_chip_sel_n, .i_one_chip_mode, .i_dir_in,
  .i_rx_bytes, .i_tx_room, .i_interrupt_status_three, .i_interrupt_enable_three, .o_lane_a_oe_n,
  .o_lane_b_oe_n, .o_lane_a_drive_en_n, .o_cycle_stretch_flag, .o_host_interrupt, .o_fifo_ready,
  .o_fifo_ready_status_bit, .o_page_in, .o_mode, .o_rx_pop, .o_reg_wr);

// ### verif/tb_top.sv
// testbench for the host bus port
`timescale 1ns/1ns
module tb_top;
  logic i_clk = 0, i_resetn = 0, i_one_chip_mode = 0, i_lane_a_first = 1, i_word_width_select = 1;
  logic i_dir_in = 1, i_internal_busy = 0, i_tx_ready = 1, i_mode_strap = 1, i_swap_strap_n = 0, lim_en = 0;
  logic [7:0] i_interrupt_status_three = 8'h00, i_rx_bytes = 8'h00, i_tx_room = 8'h00, i_reg_rdata = 8'h96;
  gpb_pkg::gpb_word_t i_rx_word = 17'h1C33C;
  gpb_pkg::gpb_pins_t pins;
  logic [7:0] o_lane_a_data, o_lane_b_data, o_reg_wdata;
  logic [4:0] o_reg_addr;
  logic o_lane_a_oe_n, o_lane_b_oe_n, o_cycle_stretch_flag, o_cycle_ready, o_dma_request, o_host_interrupt;
  logic o_fifo_ready, o_page_in, o_swap_flag, o_fifo_ready_status_bit, o_rx_pop, o_tx_valid, o_reg_wr, o_reg_legacy;
  gpb_pkg::gpb_mode_t o_mode;
  gpb_pkg::gpb_word_t o_tx_word, w;
  gpb_pkg::gpb_word_t txq[$];
  logic [15:0] rdat;
  logic [13:0] wlast;
  logic ok, sseen, aon;
  int npop = 0, err_total = 0, n_tests = 0;
  always #2 i_clk = ~i_clk;
  gpb_host_model gpb_host_model_inst (.i_clk, .i_ready(o_cycle_ready), .i_a(o_lane_a_data),
    .i_b(o_lane_b_data), .o_pins(pins));
  gpb_host_port gpb_host_port_inst (.i_clk, .i_resetn, .i_lane_a_select_n(pins.a_sel_n),
    .i_lane_b_select_n(pins.b_sel_n), .i_chip_sel_n(pins.cs_n), .i_read_strobe_n(pins.rd_n),
    .i_write_strobe_n(pins.wr_n), .i_dma_ack_n(pins.dack_n), .i_prefetch_read_n(pins.pref_n),
    .i_addr(pins.addr), .i_lane_a_data(pins.data.a), .i_lane_b_data(pins.data.b), .o_lane_a_data,
    .o_lane_b_data, .o_lane_a_oe_n, .o_lane_b_oe_n, .o_lane_a_drive_en_n(), .o_lane_b_drive_en_n(),
    .o_cycle_stretch_flag, .o_cycle_ready, .o_dma_request, .o_host_interrupt, .o_fifo_ready,
    .i_page_in_select(pins.page), .i_mode_strap, .i_swap_strap_n, .o_page_in, .o_swap_flag, .o_mode,
    .o_fifo_ready_status_bit, .i_one_chip_mode, .i_lane_a_first, .i_word_width_select, .i_dir_in,
    .i_dma_limit_enable(lim_en), .i_limit_by_time_or_count(1'h1), .i_limit_value(16'h0003),
    .i_interrupt_status_three, .i_interrupt_enable_three(8'hFF), .i_internal_busy, .i_rx_bytes,
    .i_tx_room, .i_rx_word, .o_rx_pop, .o_tx_word, .o_tx_valid, .i_tx_ready, .o_reg_addr, .o_reg_wdata,
    .o_reg_wr, .o_reg_rd(), .o_reg_legacy, .i_reg_rdata);
  // record what the port hands to the core and the host
  always @(posedge i_clk)
  begin
    if (o_reg_wr === 1'h1) wlast = {o_reg_legacy, o_reg_addr, o_reg_wdata};
    if (o_rx_pop === 1'h1) npop++;
    if (o_cycle_stretch_flag === 1'h1) sseen = 1'h1;
    if (o_lane_a_oe_n === 1'h0) aon = 1'h1;
    if (o_tx_valid === 1'h1 && i_tx_ready === 1'h1) txq.push_back(o_tx_word);
  end
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic acc(input logic dma, input logic rd, input logic [1:0] ln, input logic [4:0] a, input logic [15:0] d);
    sseen = 1'h0;
    aon = 1'h0;
    gpb_host_model_inst.access(dma, rd, ln, a, d, rdat, ok);
  endtask
  task automatic t_straps;
    chk(o_mode, gpb_pkg::MODE_COMPAT_A);
    chk(o_swap_flag, 1'h1);
    @(posedge i_clk);
    i_one_chip_mode <= 1'h1;
  endtask
  task automatic t_lanes;
    for (int i = 0; i < 2; i++)
    begin
      acc(0, 0, i ? 2'h2 : 2'h1, 5'h03, 16'hA55A);
      chk(ok, 1'h1);
      chk(wlast, {1'h0, 5'h03, i ? 8'h5A : 8'hA5});
      chk(sseen, 1'h0);
      acc(0, 1, i ? 2'h2 : 2'h1, 5'h05, 16'h0000);
      chk(i ? rdat[7:0] : rdat[15:8], 8'h96);
      chk(aon, !i);
    end
  endtask
  task automatic t_legacy;
    @(posedge i_clk);
    i_one_chip_mode <= 1'h0;
    for (int i = 0; i < 32; i++)
      if (i != 24)
      begin
        acc(0, 0, 2'h2, i[4:0], 16'(i));
        chk(wlast, {gpb_pkg::LEGACY_MAP[i], i[4:0], i[7:0]});
        chk(sseen, gpb_pkg::LEGACY_MAP[i]);
      end
  endtask
  task automatic t_busy;
    @(posedge i_clk);
    i_internal_busy <= 1'h1;
    fork
      acc(0, 0, 2'h1, 5'h02, 16'h7700);
      begin
        repeat (20) @(posedge i_clk);
        chk(o_cycle_ready, 1'h0);
        chk(o_cycle_stretch_flag, 1'h1);
        i_internal_busy <= 1'h0;
      end
    join
    chk(ok, 1'h1);
    chk(wlast, {1'h1, 5'h02, 8'h77});
  endtask
  task automatic t_word;
    int n;
    @(posedge i_clk);
    i_one_chip_mode <= 1'h1;
    for (int i = 0; i < 2; i++)
    begin
      @(posedge i_clk);
      i_lane_a_first <= i[0];
      acc(0, 0, 2'h0, 5'h18, 16'h1122);
      chk(txq.pop_front(), i ? 17'h11122 : 17'h12211);
    end
    acc(0, 0, 2'h1, 5'h18, 16'h3344);
    w = txq.pop_front();
    chk({w.two, w.first}, 9'h033);
    n = wlast;
    acc(0, 0, 2'h0, 5'h03, 16'h5566);
    chk(ok, 1'h0);
    acc(0, 0, 2'h3, 5'h03, 16'h5566);
    chk(ok, 1'h0);
    chk(wlast, n[16:0]);
  endtask
  task automatic t_buf;
    @(posedge i_clk);
    i_tx_ready <= 1'h0;
    repeat (2) acc(0, 0, 2'h0, 5'h18, 16'hABCD);
    chk(ok, 1'h1);
    acc(0, 0, 2'h0, 5'h18, 16'hABCD);
    chk(ok, 1'h0);
    @(posedge i_clk);
    i_tx_ready <= 1'h1;
    repeat (4) @(posedge i_clk);
    chk(txq.size(), 2);
    txq.delete();
  endtask
  task automatic t_dma;
    int n;
    n = npop;
    acc(1, 1, 2'h2, 5'h18, 16'h0000);
    chk(rdat[7:0], 8'hC3);
    acc(1, 1, 2'h0, 5'h03, 16'h0000);
    chk(rdat, 16'hC33C);
    acc(1, 1, 2'h1, 5'h18, 16'h0000);
    chk(ok, 1'h0);
    chk(npop - n, 2);
    acc(1, 0, 2'h0, 5'h00, 16'h4455);
    chk(txq.pop_front(), 17'h14455);
  endtask
  task automatic t_pref;
    int n;
    n = npop;
    gpb_host_model_inst.set_lvl(1'h0, 1'h1);
    repeat (6) @(posedge i_clk);
    chk({o_lane_a_oe_n | o_lane_b_oe_n, o_lane_a_data, o_lane_b_data}, 17'h0C33C);
    chk(o_page_in, 1'h1);
    gpb_host_model_inst.set_lvl(1'h1, 1'h0);
    repeat (6) @(posedge i_clk);
    chk(npop - n, 0);
  endtask
  task automatic t_dreq;
    for (int d = 0; d < 4; d++)
      for (int x = 0; x < 2; x++)
        for (int f = 0; f < 3; f++)
        begin
          @(posedge i_clk);
          i_dir_in <= d != 0;
          lim_en <= d == 3;
          i_word_width_select <= x[0];
          i_rx_bytes <= d[1] ? 8'h08 : f[7:0];
          i_tx_room <= 8'(2 - f);
          i_interrupt_status_three <= f[7:0];
          repeat (5) @(posedge i_clk);
          if (d < 2) chk(o_dma_request, d ? f > x : 2 - f > x);
          else chk({o_fifo_ready, o_fifo_ready_status_bit, o_dma_request}, {2'h3, d == 2});
        end
  endtask
  // main sequence
  initial
  begin
    repeat (12) @(posedge i_clk);
    i_resetn <= 1'h1;
    repeat (4) @(posedge i_clk);
    t_straps;
    t_lanes;
    t_legacy;
    t_busy;
    t_word;
    t_buf;
    t_dma;
    t_pref;
    t_dreq;
    print_verdict;
  end
  // watchdog
  initial
  begin
    repeat (30000) @(posedge i_clk);
    err_total++;
    print_verdict;
  end
endmodule
